// file: include/motion_cfg_pkg.sv
// constants for the motion event configuration register bank
// assumes a 32-bit apb slave, registers on word addresses of index*4
package motion_cfg_pkg;
	// ****************************************************
	// register indices and bus geometry
	// ****************************************************
	localparam int          ADDR_W         = 12;
	localparam int          DATA_W         = 32;
	localparam int          IDX_W          = ADDR_W - 2;
	localparam logic [IDX_W-1:0] IDX_ORIENT_HI  = 10'h066;
	localparam logic [IDX_W-1:0] IDX_FLAT_ANGLE = 10'h067;
	localparam logic [IDX_W-1:0] IDX_FLAT_TIME  = 10'h068;
	localparam logic [IDX_W-1:0] IDX_FOC        = 10'h069;
	localparam logic [IDX_W-1:0] IDX_MISC       = 10'h06A;
	localparam logic [IDX_W-1:0] IDX_IRQ_STAT   = 10'h07C;
	localparam logic [IDX_W-1:0] IDX_IRQ_MASK   = 10'h07D;
	// ****************************************************
	// reset values and writable bit masks
	// ****************************************************
	localparam logic [7:0] RST_ORIENT_HI  = 8'h48;
	localparam logic [7:0] RST_FLAT_ANGLE = 8'h08;
	localparam logic [7:0] RST_FLAT_TIME  = 8'h11;
	localparam logic [7:0] RST_FOC        = 8'h00;
	localparam logic [7:0] RST_MISC       = 8'h00;
	localparam logic [7:0] RST_IRQ        = 8'h00;
	localparam logic [7:0] MSK_ORIENT_HI  = 8'hFF;
	localparam logic [7:0] MSK_FLAT_ANGLE = 8'h3F;
	localparam logic [7:0] MSK_FLAT_TIME  = 8'h37;
	localparam logic [7:0] MSK_FOC        = 8'h7F;
	localparam logic [7:0] MSK_MISC       = 8'h02;
	localparam logic [7:0] MSK_IRQ        = 8'h07;
	// ****************************************************
	// field positions
	// ****************************************************
	localparam int BIT_AXIS_ROT  = 7;
	localparam int BIT_UD_EN     = 6;
	localparam int BIT_HOLD_LO   = 4;
	localparam int BIT_GYR_FOC   = 6;
	localparam int BIT_ACC_X_LO  = 4;
	localparam int BIT_ACC_Y_LO  = 2;
	localparam int BIT_ACC_Z_LO  = 0;
	localparam int BIT_NVM_EN    = 1;
	localparam int IRQ_ORIENT    = 0;
	localparam int IRQ_FLAT      = 1;
	localparam int IRQ_NVM_BLK   = 2;
	// ****************************************************
	// timing
	// ****************************************************
	localparam int CLK_PERIOD_NS = 50;
	localparam int MS_NS         = 1000000;
	localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
	localparam int HOLD_W        = 12;
	localparam logic [HOLD_W-1:0] HOLD_MS_0 = 12'h000;
	localparam logic [HOLD_W-1:0] HOLD_MS_1 = 12'd640;
	localparam logic [HOLD_W-1:0] HOLD_MS_2 = 12'd1280;
	localparam logic [HOLD_W-1:0] HOLD_MS_3 = 12'd2560;
endpackage : motion_cfg_pkg

// file: rtl/motion_event_config_regs.sv
// motion event configuration register bank with apb slave
// assumes detector inputs and sensor data are on clk; apb master on clk
`timescale 1ns/1ps
`default_nettype none

// Function
// RL1 - axis rotate bit set maps x<-y, y<-z, z<-x; clear passes axes
// RL2 - up/down change raises orientation event only when its enable is set
// RL3 - six-bit orientation blocking angle field, bits five to zero
// RL4 - six-bit flat angle threshold field sets the flat tilt limit
// RL5 - flat must stay stable 0, 640, 1280 or 2560 ms before event
// RL6 - three-bit flat hysteresis field drives the flat decision
// RL7 - gyro fast calibration bit enables all three gyro axes together
// RL8 - per-axis accel calibration target: off, +1 g, -1 g, 0 g
// RL9 - memory programming passes only while the write allow bit is one
// RL10 - software writes zero to reserved bits, ignores their read value
// RL11 - reset loads every field's printed default
module motion_event_config_regs
	import motion_cfg_pkg::*;
#(
	parameter int SENS_W    = 16,
	parameter int MS_CYC    = MS_CYCLES
) (
	input  wire logic              clk,
	input  wire logic              arst_n,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [DATA_W-1:0] pwdata,
	output logic      [DATA_W-1:0] prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic [SENS_W-1:0] sensor_x,
	input  wire logic [SENS_W-1:0] sensor_y,
	input  wire logic [SENS_W-1:0] sensor_z,
	output logic      [SENS_W-1:0] reported_x,
	output logic      [SENS_W-1:0] reported_y,
	output logic      [SENS_W-1:0] reported_z,
	input  wire logic              updown_bit,
	input  wire logic              flat_state,
	output logic      [5:0]        orient_block_angle,
	output logic      [5:0]        flat_angle_thr,
	output logic      [2:0]        flat_hysteresis,
	output logic      [2:0]        gyro_foc_en,
	output logic      [1:0]        acc_foc_x,
	output logic      [1:0]        acc_foc_y,
	output logic      [1:0]        acc_foc_z,
	input  wire logic              nvm_prog_req,
	output logic                   nvm_prog_go,
	output logic                   irq
);

	// ****************************************************
	// register storage
	// ****************************************************
	logic [7:0]         orient_hi_ff;
	logic [7:0]         flat_angle_ff;
	logic [7:0]         flat_time_ff;
	logic [7:0]         fast_cal_ff;
	logic [7:0]         misc_ff;
	logic [7:0]         irq_stat_ff;
	logic [7:0]         irq_mask_ff;
	logic [DATA_W-1:0]  prdata_ff;
	logic [IDX_W-1:0]   idx;
	logic               wr_acc;
	logic               rd_acc;
	logic               hit;
	logic [7:0]         rd_byte;
	logic [7:0]         wbyte;
	logic [7:0]         events;
	logic [7:0]         nxt_irq_stat;

	assign idx    = paddr[ADDR_W-1:2];
	assign wbyte  = pwdata[7:0];
	assign pready = 1'b1;
	assign wr_acc = psel & penable & pwrite & hit;
	// read data captured in setup so it stands in the access cycle
	assign rd_acc = psel & ~penable & ~pwrite;

	always_comb begin
		hit     = 1'b1;
		rd_byte = 8'h00;
		case (idx)
			IDX_ORIENT_HI:  rd_byte = orient_hi_ff;
			IDX_FLAT_ANGLE: rd_byte = flat_angle_ff;
			IDX_FLAT_TIME:  rd_byte = flat_time_ff;
			IDX_FOC:        rd_byte = fast_cal_ff;
			IDX_MISC:       rd_byte = misc_ff;
			IDX_IRQ_STAT:   rd_byte = irq_stat_ff;
			IDX_IRQ_MASK:   rd_byte = irq_mask_ff;
			default:        hit     = 1'b0;
		endcase
	end

	assign pslverr = psel & penable & ~hit & (paddr[1:0] == 2'b00)
		| psel & penable & (paddr[1:0] != 2'b00);

	// ****************************************************
	// configuration writes
	// ****************************************************
	// reserved bits are masked off and read as zero [RL10]
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			orient_hi_ff  <= RST_ORIENT_HI; // [RL11]
			flat_angle_ff <= RST_FLAT_ANGLE; // [RL11]
			flat_time_ff  <= RST_FLAT_TIME; // [RL11]
			fast_cal_ff   <= RST_FOC; // [RL11]
			misc_ff       <= RST_MISC; // [RL11]
			irq_mask_ff   <= RST_IRQ;
		end else if (wr_acc && paddr[1:0] == 2'b00) begin
			case (idx)
				IDX_ORIENT_HI:  orient_hi_ff  <= wbyte & MSK_ORIENT_HI;
				IDX_FLAT_ANGLE: flat_angle_ff <= wbyte & MSK_FLAT_ANGLE;
				IDX_FLAT_TIME:  flat_time_ff  <= wbyte & MSK_FLAT_TIME;
				IDX_FOC:        fast_cal_ff   <= wbyte & MSK_FOC;
				IDX_MISC:       misc_ff       <= wbyte & MSK_MISC;
				IDX_IRQ_MASK:   irq_mask_ff   <= wbyte & MSK_IRQ;
				default: ;
			endcase
		end
	end

	// ****************************************************
	// read data
	// ****************************************************
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			prdata_ff <= '0;
		end else if (rd_acc && paddr[1:0] == 2'b00) begin
			prdata_ff <= {{(DATA_W-8){1'b0}}, rd_byte};
		end else if (rd_acc) begin
			prdata_ff <= '0;
		end
	end

	always_comb begin
		prdata = prdata_ff;
	end

	// ****************************************************
	// configuration outputs
	// ****************************************************
	assign orient_block_angle = orient_hi_ff[5:0]; // [RL3]
	assign flat_angle_thr     = flat_angle_ff[5:0]; // [RL4]
	assign flat_hysteresis    = flat_time_ff[2:0]; // [RL6]
	assign gyro_foc_en        = {3{fast_cal_ff[BIT_GYR_FOC]}}; // [RL7]
	assign acc_foc_x = fast_cal_ff[BIT_ACC_X_LO +: 2]; // [RL8]
	assign acc_foc_y = fast_cal_ff[BIT_ACC_Y_LO +: 2]; // [RL8]
	assign acc_foc_z = fast_cal_ff[BIT_ACC_Z_LO +: 2]; // [RL8]
	assign nvm_prog_go = nvm_prog_req & misc_ff[BIT_NVM_EN]; // [RL9]

	// ****************************************************
	// axis remapping
	// ****************************************************
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			reported_x <= '0;
			reported_y <= '0;
			reported_z <= '0;
		end else if (orient_hi_ff[BIT_AXIS_ROT]) begin
			reported_x <= sensor_y; // [RL1]
			reported_y <= sensor_z; // [RL1]
			reported_z <= sensor_x; // [RL1]
		end else begin
			reported_x <= sensor_x; // [RL1]
			reported_y <= sensor_y; // [RL1]
			reported_z <= sensor_z; // [RL1]
		end
	end

	// ****************************************************
	// up/down change detect
	// ****************************************************
	logic updown_prev_ff;
	logic ud_event;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			updown_prev_ff <= 1'b0;
		end else begin
			updown_prev_ff <= updown_bit;
		end
	end

	assign ud_event = (updown_bit ^ updown_prev_ff)
		& orient_hi_ff[BIT_UD_EN]; // [RL2]

	// ****************************************************
	// millisecond tick
	// ****************************************************
	logic [31:0] ms_div_ff;
	logic        ms_tick;

	assign ms_tick = (ms_div_ff == 32'(MS_CYC - 1));

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ms_div_ff <= '0;
		end else if (ms_tick) begin
			ms_div_ff <= '0;
		end else begin
			ms_div_ff <= ms_div_ff + 32'h1;
		end
	end

	// ****************************************************
	// flat hold timer
	// ****************************************************
	logic              flat_prev_ff;
	logic              flat_armed_ff;
	logic [HOLD_W-1:0] hold_cnt_ff;
	logic [HOLD_W-1:0] hold_target;
	logic              flat_event;

	always_comb begin
		case (flat_time_ff[BIT_HOLD_LO +: 2]) // [RL5]
			2'b00:   hold_target = HOLD_MS_0;
			2'b01:   hold_target = HOLD_MS_1;
			2'b10:   hold_target = HOLD_MS_2;
			2'b11:   hold_target = HOLD_MS_3;
			default: hold_target = HOLD_MS_0;
		endcase
	end

	assign flat_event = flat_armed_ff & (flat_state == flat_prev_ff)
		& (hold_cnt_ff >= hold_target); // [RL5]

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			flat_prev_ff  <= 1'b0;
			flat_armed_ff <= 1'b0;
			hold_cnt_ff   <= '0;
		end else begin
			flat_prev_ff <= flat_state;
			if (flat_state != flat_prev_ff) begin
				flat_armed_ff <= 1'b1;
				hold_cnt_ff   <= '0;
			end else if (flat_event) begin
				flat_armed_ff <= 1'b0;
			end else if (flat_armed_ff && ms_tick) begin
				hold_cnt_ff <= hold_cnt_ff + 12'h001;
			end
		end
	end

	// ****************************************************
	// interrupt status and output
	// ****************************************************
	always_comb begin
		events              = 8'h00;
		events[IRQ_ORIENT]  = ud_event;
		events[IRQ_FLAT]    = flat_event;
		events[IRQ_NVM_BLK] = nvm_prog_req & ~misc_ff[BIT_NVM_EN];
		nxt_irq_stat        = irq_stat_ff;
		if (wr_acc && idx == IDX_IRQ_STAT && paddr[1:0] == 2'b00) begin
			nxt_irq_stat = irq_stat_ff & ~wbyte;
		end
		// set wins over a clear in the same cycle
		nxt_irq_stat = (nxt_irq_stat | events) & MSK_IRQ;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_stat_ff <= RST_IRQ;
		end else begin
			irq_stat_ff <= nxt_irq_stat;
		end
	end

	assign irq = |(irq_stat_ff & irq_mask_ff);

	// ****************************************************
	// assertions
	// ****************************************************
	a_remap_on: assert property ( // [RL1]
		@(posedge clk) disable iff (!arst_n)
		orient_hi_ff[BIT_AXIS_ROT] |=> reported_x == $past(sensor_y)
			&& reported_z == $past(sensor_x))
		else $error("rotated axes not mapped");

	a_remap_off: assert property ( // [RL1]
		@(posedge clk) disable iff (!arst_n)
		!orient_hi_ff[BIT_AXIS_ROT] |=> reported_y == $past(sensor_y))
		else $error("axes not passed through");

	a_updown_raise: assert property ( // [RL2]
		@(posedge clk) disable iff (!arst_n)
		orient_hi_ff[BIT_UD_EN] && $changed(updown_bit)
			|=> irq_stat_ff[IRQ_ORIENT])
		else $error("up/down change lost");

	a_updown_masked: assert property ( // [RL2]
		@(posedge clk) disable iff (!arst_n)
		!orient_hi_ff[BIT_UD_EN] && !irq_stat_ff[IRQ_ORIENT]
			&& !flat_event && !(wr_acc && idx == IDX_ORIENT_HI)
			|=> !irq_stat_ff[IRQ_ORIENT])
		else $error("masked up/down change raised");

	a_block_angle: assert property ( // [RL3]
		@(posedge clk) disable iff (!arst_n)
		wr_acc && idx == IDX_ORIENT_HI && paddr[1:0] == 2'b00
			|=> orient_block_angle == $past(pwdata[5:0]))
		else $error("blocking angle not stored");

	a_flat_thr: assert property ( // [RL4]
		@(posedge clk) disable iff (!arst_n)
		wr_acc && idx == IDX_FLAT_ANGLE && paddr[1:0] == 2'b00
			|=> flat_angle_thr == $past(pwdata[5:0]))
		else $error("flat threshold not stored");

	a_acc_target: assert property ( // [RL8]
		@(posedge clk) disable iff (!arst_n)
		wr_acc && idx == IDX_FOC && paddr[1:0] == 2'b00
			|=> acc_foc_x == $past(pwdata[BIT_ACC_X_LO +: 2]))
		else $error("accel target not stored");

	a_flat_zero: assert property ( // [RL5]
		@(posedge clk) disable iff (!arst_n)
		flat_time_ff[BIT_HOLD_LO +: 2] == 2'b00 && $changed(flat_state)
			##1 $stable(flat_state) && $stable(flat_time_ff)
			|=> irq_stat_ff[IRQ_FLAT])
		else $error("zero hold flat event missing");

	a_flat_early: assert property ( // [RL5]
		@(posedge clk) disable iff (!arst_n)
		flat_time_ff[BIT_HOLD_LO +: 2] != 2'b00 && $changed(flat_state)
			&& !(wr_acc && idx == IDX_FLAT_TIME)
			|=> !flat_event)
		else $error("flat event before hold time");

	a_gyro_all: assert property ( // [RL7]
		@(posedge clk) disable iff (!arst_n)
		fast_cal_ff[BIT_GYR_FOC] |-> gyro_foc_en == 3'b111)
		else $error("gyro axes not enabled together");

	a_nvm_block: assert property ( // [RL9]
		@(posedge clk) disable iff (!arst_n)
		!misc_ff[BIT_NVM_EN] |-> !nvm_prog_go)
		else $error("programming not blocked");

	a_nvm_blk_flag: assert property ( // [RL9]
		@(posedge clk) disable iff (!arst_n)
		nvm_prog_req && !misc_ff[BIT_NVM_EN]
			|=> irq_stat_ff[IRQ_NVM_BLK])
		else $error("blocked request not flagged");

	a_reset_vals: assert property ( // [RL11]
		@(posedge clk)
		$rose(arst_n) |-> orient_hi_ff == RST_ORIENT_HI
			&& flat_time_ff == RST_FLAT_TIME)
		else $error("reset defaults wrong");

endmodule : motion_event_config_regs

`default_nettype wire

// file: dv/motion_event_config_regs_tb.sv
// testbench for the motion event configuration register bank
// assumes apb slave on clk, ms counter shortened by MS_CYC
`timescale 1ns/1ps
`default_nettype none
module motion_event_config_regs_tb
	import motion_cfg_pkg::*;
;
	localparam int MSC = 4;
	logic              clk, arst_n, psel, penable, pwrite, pready, pslverr;
	logic              ud, fl, nreq, ngo, irq, er;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata, rd;
	logic [15:0]       sx, sy, sz, rx, ry, rz;
	logic [5:0]        oba, fat;
	logic [2:0]        fhy, gfe;
	logic [1:0]        afx, afy, afz;
	int                err_count, tests_run, n;
	logic [7:0]        v;

	motion_event_config_regs #(.MS_CYC(MSC)) motion_event_config_regs_i (
		.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .sensor_x(sx), .sensor_y(sy),
		.sensor_z(sz), .reported_x(rx), .reported_y(ry), .reported_z(rz),
		.updown_bit(ud), .flat_state(fl), .orient_block_angle(oba),
		.flat_angle_thr(fat), .flat_hysteresis(fhy), .gyro_foc_en(gfe),
		.acc_foc_x(afx), .acc_foc_y(afy), .acc_foc_z(afz),
		.nvm_prog_req(nreq), .nvm_prog_go(ngo), .irq(irq)
	);

	always #25 clk = ~clk;

	// ****************************************************
	// helpers
	// ****************************************************
	function automatic logic [11:0] a(input logic [9:0] idx);
		return {idx, 2'b00};
	endfunction : a

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : finish_test

	task automatic apb(input logic w, input logic [11:0] ad,
		input logic [31:0] d);
		int k;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		er = pslverr;
		rd = prdata;
		if (k >= 20) begin
			err_count++;
			finish_test();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb

	task automatic rdchk(input logic [11:0] ad, input logic [31:0] exp);
		apb(1'b0, ad, 32'h0);
		chk(rd, exp);
	endtask : rdchk

	// ****************************************************
	// scenarios
	// ****************************************************
	task automatic t_reset;
		rdchk(a(IDX_ORIENT_HI), 32'h48);
		rdchk(a(IDX_FLAT_ANGLE), 32'h08);
		rdchk(a(IDX_FLAT_TIME), 32'h11);
		rdchk(a(IDX_FOC), 32'h0);
		rdchk(a(IDX_MISC), 32'h0);
		rdchk(a(IDX_IRQ_MASK), 32'h0);
		apb(1'b1, 12'hFFC, 32'h0);
		chk(er, 1'b1);
		apb(1'b1, a(IDX_MISC) | 12'h1, 32'h2);
		chk(er, 1'b1);
		rdchk(a(IDX_MISC), 32'h0);
		apb(1'b0, 12'hFFC, 32'h0);
		chk(er, 1'b1);
		chk(rd, 32'h0);
		$display("test reset done");
	endtask : t_reset

	task automatic t_fields;
		for (int i = 0; i < 4; i++) begin
			v = {4{i[1:0]}};
			apb(1'b1, a(IDX_ORIENT_HI), {24'hFFFFFF, v});
			apb(1'b1, a(IDX_FLAT_ANGLE), {24'h0, v & MSK_FLAT_ANGLE});
			apb(1'b1, a(IDX_FLAT_TIME), {24'h0, v & MSK_FLAT_TIME});
			apb(1'b1, a(IDX_FOC), {24'h0, v & MSK_FOC});
			chk(oba, v[5:0]);
			chk(fat, v[5:0]);
			chk(fhy, v[2:0]);
			chk(gfe, {3{v[6]}});
			chk({afx, afy, afz}, v[5:0]);
			rdchk(a(IDX_ORIENT_HI), {24'h0, v});
			rdchk(a(IDX_FLAT_TIME), {24'h0, v & MSK_FLAT_TIME});
			rdchk(a(IDX_FOC), {24'h0, v & MSK_FOC});
		end
		$display("test fields done");
	endtask : t_fields

	task automatic t_remap;
		sx <= 16'h1111;
		sy <= 16'h2222;
		sz <= 16'h3333;
		apb(1'b1, a(IDX_ORIENT_HI), 32'h48);
		repeat (2) @(posedge clk);
		chk(rx, 16'h1111);
		chk({ry, rz}, 32'h22223333);
		apb(1'b1, a(IDX_ORIENT_HI), 32'hC8);
		sx <= 16'hA5A5;
		repeat (2) @(posedge clk);
		chk(rx, 16'h2222);
		chk({ry, rz}, 32'h3333A5A5);
		$display("test remap done");
	endtask : t_remap

	task automatic t_updown;
		apb(1'b1, a(IDX_ORIENT_HI), 32'h08);
		ud <= ~ud;
		repeat (3) @(posedge clk);
		rdchk(a(IDX_IRQ_STAT), 32'h0);
		apb(1'b1, a(IDX_ORIENT_HI), 32'h48);
		ud <= ~ud;
		repeat (3) @(posedge clk);
		chk(irq, 1'b0);
		rdchk(a(IDX_IRQ_STAT), 32'h1);
		apb(1'b1, a(IDX_IRQ_MASK), 32'h1);
		@(posedge clk);
		chk(irq, 1'b1);
		apb(1'b1, a(IDX_IRQ_STAT), 32'h1);
		@(posedge clk);
		chk(irq, 1'b0);
		$display("test updown done");
	endtask : t_updown

	task automatic t_flat;
		apb(1'b1, a(IDX_IRQ_MASK), 32'h2);
		for (int j = 0; j < 4; j++) begin
			apb(1'b1, a(IDX_FLAT_TIME), {26'h0, j[1:0], 4'h0});
			fl <= ~fl;
			n = 0;
			while (irq !== 1'b1 && n < 12000) begin
				@(posedge clk);
				n++;
			end
			if (n >= 12000) begin
				err_count++;
				finish_test();
			end
			v = (j == 0) ? 8'h1 : 8'h0;
			if (j > 0)
				v = (n >= (320 << j) * MSC && n <= (320 << j) * MSC + 8);
			if (j == 0)
				v = (n <= 3);
			chk(v, 8'h1);
			apb(1'b1, a(IDX_IRQ_STAT), 32'h2);
		end
		$display("test flat done");
	endtask : t_flat

	task automatic t_nvm;
		apb(1'b1, a(IDX_IRQ_MASK), 32'h4);
		nreq <= 1'b1;
		repeat (2) @(posedge clk);
		chk({ngo, irq}, 2'b01);
		apb(1'b1, a(IDX_MISC), 32'h2);
		chk(ngo, 1'b1);
		nreq <= 1'b0;
		@(posedge clk);
		apb(1'b1, a(IDX_IRQ_STAT), 32'h4);
		@(posedge clk);
		chk(irq, 1'b0);
		$display("test nvm done");
	endtask : t_nvm

	initial begin
		clk = 1'b0;
		arst_n = 1'b0;
		{psel, penable, pwrite, ud, fl, nreq} = '0;
		paddr = '0;
		pwdata = '0;
		{sx, sy, sz} = '0;
		err_count = 0;
		tests_run = 0;
		repeat (8) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		t_reset();
		t_fields();
		t_remap();
		t_updown();
		t_flat();
		t_nvm();
		finish_test();
	end
endmodule : motion_event_config_regs_tb
`default_nettype wire
